// ===== rtl/key_map.svh
// Bit positions, register offsets, reset values and codes for the IPv6 slice key.
// Assumes inclusion by bare name from the rtl/ directory.
`ifndef KEY_MAP_SVH
`define KEY_MAP_SVH

`define KEY_W           232
`define KP_PORT_HI      231
`define KP_PORT_LO      224
`define KP_STAG_HI      223
`define KP_STAG_LO      222
`define KP_CTAG_HI      221
`define KP_CTAG_LO      220
`define KP_L2_HI        219
`define KP_L2_LO        218
`define KP_L3_HI        217
`define KP_L3_LO        216
`define KP_TC_HI        215
`define KP_TC_LO        208
`define KP_NH_HI        207
`define KP_NH_LO        200
`define KP_FRAG         199
`define KP_NONFIRST     198
`define KP_AUTH         197
`define KP_HOP_HI       196
`define KP_HOP_LO       195
`define KP_PPPOE        194
`define KP_RSV1         193
`define KP_UFV8         192
`define KP_UFV_HI       191
`define KP_UFV_LO       184
`define KP_SVAL_HI      183
`define KP_SVAL_LO      168
`define KP_CVAL_HI      167
`define KP_CVAL_LO      152
`define KP_UF_HI        151
`define KP_UF_LO        8
`define KP_RSV4_HI      7
`define KP_RSV4_LO      4
`define KP_SLICE_HI     3
`define KP_SLICE_LO     2
`define KP_SVALID_HI    1
`define KP_SVALID_LO    0

`define N_USER_FIELDS   9
`define UF_W            16
`define N_PORTS         8

`define L3_CODE_IPV6    2'h1
`define SLICE_VALID_ON  2'h3
`define TAG_NONE        2'h0
`define TAG_VID_ZERO    2'h1
`define TAG_VID_NZ      2'h3
`define HOP_ZERO        2'h0
`define HOP_ONE         2'h1
`define HOP_OTHER       2'h2
`define HOP_MAX         2'h3

`define APB_AW          12
`define REG_CTRL        12'h000
`define REG_PPPOE       12'h004
`define REG_STATUS      12'h008
`define CTRL_RST        3'h4
`define PPPOE_RST       8'h00
`define CTRL_SLICE_HI   1
`define CTRL_SLICE_LO   0
`define CTRL_ENABLE     2

`endif

// ===== rtl/key_pkg.sv
// Types shared by the IPv6 slice key builder and its helpers.
// Assumes key_map.svh is on the include path.
`include "key_map.svh"

package key_pkg;
    typedef logic [`KEY_W-1:0] search_key_t;
    typedef logic [1:0]        tag_code_t;
    typedef logic [1:0]        hop_code_t;
    typedef logic [`UF_W-1:0]  user_field_t;
endpackage : key_pkg

// ===== rtl/tag_status_enc.sv
// Encodes presence and identifier of one received VLAN tag into a 2-bit status.
// Assumes the tag is the 16-bit tag control word, identifier in the low 12 bits.
`include "key_map.svh"

module tag_status_enc
    import key_pkg::*;
(
    input  wire logic        present, // Tag was in the packet
    input  wire logic [15:0] tag,     // Tag control word
    output tag_code_t        code     // Status code
);
    always_comb begin
        if (!present) begin
            code = `TAG_NONE;
        end else if (tag[11:0] == 12'h000) begin
            code = `TAG_VID_ZERO;
        end else begin
            code = `TAG_VID_NZ;
        end
    end
endmodule // tag_status_enc

// ===== rtl/hop_limit_class.sv
// Sorts an IPv6 hop limit into the 2-bit range code of the search key.
// Assumes an unsigned 8-bit hop limit from the parser.
`include "key_map.svh"

module hop_limit_class
    import key_pkg::*;
(
    input  wire logic [7:0] hop_limit, // Parsed hop limit
    output hop_code_t       code       // Range code
);
    always_comb begin
        case (hop_limit)
            8'h00:   code = `HOP_ZERO;
            8'h01:   code = `HOP_ONE;
            8'hff:   code = `HOP_MAX;
            default: code = `HOP_OTHER;
        endcase
    end
endmodule // hop_limit_class

// ===== rtl/ipv6_slice_search_key.sv
// IPv6 search key builder for classifier slices 0..3, with an APB register slave.
// Assumes parser facts are valid in the pkt_valid cycle; key appears one cycle later.
`include "key_map.svh"

module ipv6_slice_search_key
    import key_pkg::*;
(
    input  wire logic                 ref_clk,            // Core clock
    input  wire logic                 reset,              // Sync reset, high
    // APB slave
    input  wire logic                 psel,               // Select
    input  wire logic                 penable,            // Access phase
    input  wire logic                 pwrite,             // Write
    input  wire logic [`APB_AW-1:0]   paddr,              // Byte address
    input  wire logic [31:0]          pwdata,             // Write data
    input  wire logic [3:0]           pstrb,              // Byte strobes
    output logic                      pready,             // Ready
    output logic [31:0]               prdata,             // Read data
    output logic                      pslverr,            // Error
    // Parser side
    input  wire logic                 pkt_valid,          // Packet facts valid
    input  wire logic                 is_ipv6,            // Packet classed IPv6
    input  wire logic [2:0]           ingress_port,       // Receiving port
    input  wire logic                 s_tag_present,      // Outer tag received
    input  wire logic [15:0]          s_tag,              // Outer tag word
    input  wire logic                 c_tag_present,      // Inner tag received
    input  wire logic [15:0]          c_tag,              // Inner tag word
    input  wire logic [15:0]          def_s_tag,          // Port default outer
    input  wire logic [15:0]          def_c_tag,          // Port default inner
    input  wire logic [1:0]           link_encap_code,    // Link framing
    input  wire logic [7:0]           traffic_class_byte, // Traffic class
    input  wire logic [7:0]           last_next_header,   // Last next header
    input  wire logic                 fragment_flag,      // Fragmented
    input  wire logic                 non_first_frag,     // Later fragment
    input  wire logic                 auth_header_flag,   // Authenticated
    input  wire logic [7:0]           hop_limit,          // Hop limit
    input  wire logic                 flag_a,             // Session stage seen
    input  wire logic [8:0]           user_field_valid,   // Field valid flags
    input  wire logic [143:0]         ipv6_user_field,    // Fields 8..0
    // Lookup side
    output search_key_t               key,                // Search key
    output logic                      key_valid           // Key pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0]  ctrl_q,      ctrl_d;
    logic [7:0]  pppoe_en_q,  pppoe_en_d;
    logic [15:0] built_q,     built_d;
    logic [15:0] skipped_q,   skipped_d;
    logic        pready_q,    pready_d;
    logic        pslverr_q,   pslverr_d;
    logic [31:0] prdata_q,    prdata_d;
    search_key_t key_q,       key_d;
    logic        key_valid_q, key_valid_d;

    logic        setup;
    logic        wr_fire;
    logic        mapped;
    logic [31:0] rd_mux;

    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign mapped  = (paddr == `REG_CTRL) || (paddr == `REG_PPPOE) || (paddr == `REG_STATUS);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `REG_CTRL:   rd_mux = {29'h0000_0000, ctrl_q};
            `REG_PPPOE:  rd_mux = {24'h00_0000, pppoe_en_q};
            `REG_STATUS: rd_mux = {skipped_q, built_q};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase, ready for exactly one cycle
    always_comb begin
        pready_d   = setup;
        pslverr_d  = setup && !mapped;
        prdata_d   = setup ? rd_mux : prdata_q;
        ctrl_d     = ctrl_q;
        pppoe_en_d = pppoe_en_q;
        if (wr_fire && pstrb[0]) begin
            if (paddr == `REG_CTRL) begin
                ctrl_d = pwdata[2:0];
            end
            if (paddr == `REG_PPPOE) begin
                pppoe_en_d = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            ctrl_q     <= `CTRL_RST;
            pppoe_en_q <= `PPPOE_RST;
        end else begin
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            prdata_q   <= prdata_d;
            ctrl_q     <= ctrl_d;
            pppoe_en_q <= pppoe_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field encoders
    tag_code_t s_code;
    tag_code_t c_code;
    hop_code_t hop_code;

    tag_status_enc u_s_status (
        .present (s_tag_present),
        .tag     (s_tag),
        .code    (s_code)
    );

    tag_status_enc u_c_status (
        .present (c_tag_present),
        .tag     (c_tag),
        .code    (c_code)
    );

    hop_limit_class u_hop (
        .hop_limit (hop_limit),
        .code      (hop_code)
    );

    // pack fields 8..0, field k at bits 8+16k
    // invalid fields zeroed so stale parser data never reaches the match
    logic [143:0] uf_packed;
    genvar k;
    generate
        for (k = 0; k < `N_USER_FIELDS; k++) begin : g_uf
            assign uf_packed[k*16 +: 16] = user_field_valid[k] ? ipv6_user_field[k*16 +: 16] : 16'h0000;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Key assembly
    logic build;
    logic [7:0] port_onehot;

    // IPv6 layout only for IPv6 packets; others counted as skipped
    assign build       = pkt_valid && is_ipv6 && ctrl_q[`CTRL_ENABLE];
    assign port_onehot = 8'h01 << ingress_port;

    always_comb begin
        key_d       = key_q;
        key_valid_d = build;
        built_d     = built_q;
        skipped_d   = skipped_q;
        if (pkt_valid && !build) begin
            skipped_d = skipped_q + 16'h0001;
        end
        if (build) begin
            built_d = built_q + 16'h0001;
            // one 232-bit vector, port mask on top
            key_d = '0;
            key_d[`KP_PORT_HI:`KP_PORT_LO] = ~port_onehot;
            key_d[`KP_STAG_HI:`KP_STAG_LO] = s_code;
            key_d[`KP_CTAG_HI:`KP_CTAG_LO] = c_code;
            key_d[`KP_L2_HI:`KP_L2_LO] = link_encap_code;
            key_d[`KP_L3_HI:`KP_L3_LO] = `L3_CODE_IPV6;
            key_d[`KP_TC_HI:`KP_TC_LO] = traffic_class_byte;
            // last next header of the chain
            key_d[`KP_NH_HI:`KP_NH_LO] = last_next_header;
            key_d[`KP_FRAG]     = fragment_flag;
            key_d[`KP_NONFIRST] = non_first_frag;
            key_d[`KP_AUTH] = auth_header_flag;
            key_d[`KP_HOP_HI:`KP_HOP_LO] = hop_code;
            // session flag only on enabled ports, bit 193 zero
            key_d[`KP_PPPOE] = flag_a && pppoe_en_q[ingress_port];
            key_d[`KP_RSV1]  = 1'b0;
            // valid flags of fields 8 and 7..0
            key_d[`KP_UFV8]                = user_field_valid[8];
            key_d[`KP_UFV_HI:`KP_UFV_LO]   = user_field_valid[7:0];
            // outer tag from packet or port default
            key_d[`KP_SVAL_HI:`KP_SVAL_LO] = s_tag_present ? s_tag : def_s_tag;
            // inner tag, upper byte 167:160, lower 159:152
            key_d[`KP_CVAL_HI:`KP_CVAL_LO] = c_tag_present ? c_tag : def_c_tag;
            // IPv6 user field set into its slot
            key_d[`KP_UF_HI:`KP_UF_LO] = uf_packed;
            key_d[`KP_RSV4_HI:`KP_RSV4_LO]   = 4'h0;
            key_d[`KP_SLICE_HI:`KP_SLICE_LO] = ctrl_q[`CTRL_SLICE_HI:`CTRL_SLICE_LO];
            // slice valid pair so programmed rules see the slice
            key_d[`KP_SVALID_HI:`KP_SVALID_LO] = `SLICE_VALID_ON;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            key_q       <= '0;
            key_valid_q <= 1'b0;
            built_q     <= 16'h0000;
            skipped_q   <= 16'h0000;
        end else begin
            key_q       <= key_d;
            key_valid_q <= key_valid_d;
            built_q     <= built_d;
            skipped_q   <= skipped_d;
        end
    end

    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign prdata    = prdata_q;
    assign key       = key_q;
    assign key_valid = key_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    key_latency_a: assert property (build |=> key_valid_q)
        else $error("key not produced one cycle after IPv6 packet");
    non_ipv6_quiet_a: assert property (pkt_valid && !is_ipv6 |=> !key_valid_q)
        else $error("key produced for non-IPv6 packet");
    l3_mark_a: assert property (key_valid_q |-> key_q[217:216] == 2'h1)
        else $error("network layer code not IPv6");
    reserved_zero_a: assert property (key_valid_q |-> !key_q[193] && key_q[7:4] == 4'h0)
        else $error("reserved key bits not zero");
    slice_index_a: assert property (key_valid_q |-> key_q[3:2] == $past(ctrl_q[1:0]))
        else $error("slice index wrong in key");
    slice_valid_a: assert property (key_valid_q |-> key_q[1:0] == 2'h3)
        else $error("slice valid bits not 11");
    port_mask_a: assert property (key_valid_q |-> key_q[231:224] == ~(8'h01 << $past(ingress_port)))
        else $error("port mask does not clear ingress port only");
    pppoe_gate_a: assert property (build && !pppoe_en_q[ingress_port] |=> !key_q[194])
        else $error("session flag set on disabled port");
    hop_max_a: assert property (build && hop_limit == 8'hff |=> key_q[196:195] == 2'h3)
        else $error("hop limit 255 misclassified");
    stag_default_a: assert property (build && !s_tag_present
                                     |=> key_q[223:222] == 2'h0 && key_q[183:168] == $past(def_s_tag))
        else $error("outer tag default not applied");
    uf_masked_a: assert property (key_valid_q && !key_q[184] |-> key_q[23:8] == 16'h0000)
        else $error("invalid user field leaked into key");
    stag_zero_a: assert property (build && s_tag_present && s_tag[11:0] == 12'h000
                                  |=> key_q[223:222] == 2'h1)
        else $error("outer tag with identifier zero misclassified");
    ctag_nonzero_a: assert property (build && c_tag_present && c_tag[11:0] != 12'h000
                                     |=> key_q[221:220] == 2'h3)
        else $error("inner tag with nonzero identifier misclassified");
    encap_code_a: assert property (build |=> key_q[219:218] == $past(link_encap_code))
        else $error("link framing code not carried");
    next_header_a: assert property (build |=> key_q[207:200] == $past(last_next_header))
        else $error("last next header not carried");
    frag_flags_a: assert property (build
                                   |=> key_q[199] == $past(fragment_flag) && key_q[198] == $past(non_first_frag))
        else $error("fragment flags not carried");
    auth_flag_a: assert property (build |=> key_q[197] == $past(auth_header_flag))
        else $error("authentication flag not carried");
    hop_other_a: assert property (build && hop_limit > 8'h01 && hop_limit < 8'hff
                                  |=> key_q[196:195] == 2'h2)
        else $error("ordinary hop limit misclassified");
    uf_valid_a: assert property (build |=> key_q[192:184] == $past(user_field_valid))
        else $error("user field valid flags not carried");
    ctag_split_a: assert property (build && c_tag_present |=> key_q[167:152] == $past(c_tag))
        else $error("inner tag bytes not carried");
    key_hold_a: assert property (pkt_valid && !build |=> $stable(key_q))
        else $error("key changed for a refused packet");
    apb_ready_a: assert property (setup |=> pready_q ##1 !pready_q || setup)
        else $error("APB ready not a single cycle after setup");

    ipv6_key_c:  cover property (build ##1 key_valid_q);
    skipped_c:   cover property (pkt_valid && !is_ipv6);
    fragment_c:  cover property (build && fragment_flag && non_first_frag);
    apb_write_c: cover property (wr_fire && paddr == `REG_PPPOE);

endmodule // ipv6_slice_search_key

// ===== bench/key_sink.sv
// Lookup-side model: takes each key pulse and counts the keys it would search with.
// Assumes key and key_valid come straight from the key builder on ref_clk.
module key_sink
    import key_pkg::*;
(
    input  wire logic        ref_clk,   // Core clock
    input  wire logic        reset,     // Sync reset, high
    input  search_key_t      key,       // Search key
    input  wire logic        key_valid, // Key pulse
    output logic [15:0]      accepted,  // Keys taken for lookup
    output logic [15:0]      leaked     // Keys with an unflagged field set
);
    timeunit 1ns;
    timeprecision 1ps;

    logic leak;

    ////////////////////////////////////////////////////////////////////////
    // slice valid gate
    // A rule only sees a slice whose valid pair is 11
    always @(posedge ref_clk) begin
        if (reset) begin
            accepted <= 16'h0000;
        end else if (key_valid && key[1:0] == 2'h3) begin
            accepted <= accepted + 16'h0001;
        end
    end

    // fields paired with flags
    // Flag of field i sits at 184+i; an unflagged field must read zero
    always_comb begin
        leak = 1'b0;
        for (int i = 0; i < 9; i++) begin
            leak = leak | (!key[184+i] && key[8+16*i +: 16] != 16'h0000);
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            leaked <= 16'h0000;
        end else if (key_valid && leak) begin
            leaked <= leaked + 16'h0001;
        end
    end
endmodule // key_sink

// ===== bench/testbench.sv
// Self-checking bench: APB register tasks and packet tasks with expected keys.
// Assumes zero-wait APB answers may still stretch; every wait is bounded.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import key_pkg::*;

    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, pkt_valid, is_ipv6;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] ingress_port;
    logic s_tag_present, c_tag_present, fragment_flag, non_first_frag, auth_header_flag, flag_a, key_valid;
    logic [15:0] s_tag, c_tag, def_s_tag, def_c_tag, accepted, leaked;
    logic [1:0] link_encap_code;
    logic [7:0] traffic_class_byte, last_next_header, hop_limit;
    logic [8:0] user_field_valid;
    logic [143:0] ipv6_user_field;
    search_key_t key;
    int fails = 0;
    int checks = 0;
    logic [7:0] hops [6] = '{8'h00, 8'h01, 8'hff, 8'h02, 8'hfe, 8'h80};

    ipv6_slice_search_key DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pkt_valid(pkt_valid), .is_ipv6(is_ipv6), .ingress_port(ingress_port),
        .s_tag_present(s_tag_present), .s_tag(s_tag), .c_tag_present(c_tag_present), .c_tag(c_tag),
        .def_s_tag(def_s_tag), .def_c_tag(def_c_tag), .link_encap_code(link_encap_code),
        .traffic_class_byte(traffic_class_byte), .last_next_header(last_next_header),
        .fragment_flag(fragment_flag), .non_first_frag(non_first_frag), .auth_header_flag(auth_header_flag),
        .hop_limit(hop_limit), .flag_a(flag_a), .user_field_valid(user_field_valid),
        .ipv6_user_field(ipv6_user_field), .key(key), .key_valid(key_valid));
    key_sink sink (.ref_clk(ref_clk), .reset(reset), .key(key), .key_valid(key_valid), .accepted(accepted),
        .leaked(leaked));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [231:0] got, input logic [231:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic err);
        int t;
        t = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(t < 50, 1'b1, "no pready");
    endtask

    task automatic apb_read(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        check(rd, exp, "read data");
        check(err, exp_err, "pslverr");
    endtask

    task automatic apb_write(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, wd, st, rd, err);
    endtask

    function automatic logic [1:0] tag_code(input logic p, input logic [15:0] t);
        return !p ? 2'h0 : (t[11:0] == 12'h000 ? 2'h1 : 2'h3);
    endfunction

    function automatic search_key_t exp_key(input logic [1:0] sl, input logic [7:0] pp);
        search_key_t k;
        k = '0;
        k[231:224] = ~(8'h01 << ingress_port);
        k[223:222] = tag_code(s_tag_present, s_tag);
        k[221:220] = tag_code(c_tag_present, c_tag);
        k[219:218] = link_encap_code;
        k[217:216] = 2'h1;
        k[215:208] = traffic_class_byte;
        k[207:200] = last_next_header;
        k[199:197] = {fragment_flag, non_first_frag, auth_header_flag};
        k[196:195] = hop_limit == 8'h00 ? 2'h0 : hop_limit == 8'h01 ? 2'h1 : hop_limit == 8'hff ? 2'h3 : 2'h2;
        k[194] = flag_a & pp[ingress_port];
        k[192:184] = user_field_valid;
        k[183:168] = s_tag_present ? s_tag : def_s_tag;
        k[167:152] = c_tag_present ? c_tag : def_c_tag;
        for (int i = 0; i < 9; i++) begin
            if (user_field_valid[i]) k[8+16*i +: 16] = ipv6_user_field[16*i +: 16];
        end
        k[3:2] = sl;
        k[1:0] = 2'h3;
        return k;
    endfunction

    // Facts vary with n so every tag, hop and flag code comes up across a sweep
    task automatic send_pkt(input int n, input logic v6, input logic built, input logic [1:0] sl,
                            input logic [7:0] pp);
        logic [7:0] m;
        logic [143:0] uf;
        search_key_t old;
        m = 8'(n);
        old = key;
        for (int i = 0; i < 9; i++) uf[16*i +: 16] = {4'(i), 4'hc, m};
        @(posedge ref_clk);
        pkt_valid <= 1'b1;
        is_ipv6 <= v6;
        ingress_port <= m[2:0];
        s_tag_present <= m[0];
        s_tag <= m[1] ? 16'h5123 : 16'he000;
        c_tag_present <= m[1];
        c_tag <= m[2] ? 16'h0abc : 16'h3000;
        def_s_tag <= 16'h0100 + 16'(m);
        def_c_tag <= 16'h0200 + 16'(m);
        link_encap_code <= {1'b0, m[0]};
        traffic_class_byte <= m * 8'h25;
        last_next_header <= m + 8'h2b;
        fragment_flag <= m[1];
        non_first_frag <= m[2];
        auth_header_flag <= m[0] ^ m[2];
        hop_limit <= hops[n % 6];
        flag_a <= ~m[3];
        user_field_valid <= 9'h1a5 ^ 9'(m * 8'h13);
        ipv6_user_field <= uf;
        @(posedge ref_clk);
        pkt_valid <= 1'b0;
        #1;
        check(key_valid, built, "key pulse timing");
        check(key, built ? exp_key(sl, pp) : old, "key contents");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, pkt_valid, is_ipv6, ingress_port} = '0;
        {s_tag_present, c_tag_present, s_tag, c_tag, def_s_tag, def_c_tag, link_encap_code} = '0;
        {traffic_class_byte, last_next_header, fragment_flag, non_first_frag, auth_header_flag} = '0;
        {hop_limit, flag_a, user_field_valid, ipv6_user_field} = '0;
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        apb_read(12'h000, 32'h0000_0004, 1'b0);
        apb_read(12'h004, 32'h0000_0000, 1'b0);
        apb_read(12'h008, 32'h0000_0000, 1'b0);
        apb_read(12'h00c, 32'h0000_0000, 1'b1);
        // Only the low byte of the PPPoE register is writable, and only with pstrb[0] set
        apb_write(12'h004, 32'hffff_ff5a, 4'hf);
        apb_read(12'h004, 32'h0000_005a, 1'b0);
        for (int n = 0; n < 12; n++) begin
            if (n % 3 == 0) apb_write(12'h000, {29'h0, 1'b1, 2'(n / 3)}, 4'hf);
            send_pkt(n, 1'b1, 1'b1, 2'(n / 3), 8'h5a);
        end
        apb_write(12'h000, 32'h0000_0003, 4'hf);
        send_pkt(20, 1'b1, 1'b0, 2'h3, 8'h5a);
        apb_write(12'h000, 32'h0000_0004, 4'he);
        apb_read(12'h000, 32'h0000_0003, 1'b0);
        apb_write(12'h000, 32'h0000_0004, 4'hf);
        send_pkt(21, 1'b0, 1'b0, 2'h0, 8'h5a);
        apb_write(12'h008, 32'h0000_0000, 4'hf);
        apb_read(12'h008, {16'd2, 16'd12}, 1'b0);
        check(accepted, 16'd12, "keys seen by lookup");
        check(leaked, 16'd0, "unflagged field reached lookup");
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        stop_test();
    end
endmodule // testbench
